// file: design/bus_ctrl_pin_assign_mode_reg.sv
// Port E function assignment and mode register of the external bus interface.
// How it works
// - Free-cycle enable is bit 7; write once normal, never emulation, anytime special.
// - Enable 0 makes pin 7 the free-cycle flag; 1 leaves general I/O.
// - Free-cycle, pipe and read/write enables ignored in single-chip or peripheral mode.
// - Pipe status enable is bit 5 with the same write pattern.
// - Pipe enable set drives queue state on pins 6 and 5.
// - Bus clock disable is bit 4; writable in normal and special, never emulation.
// - Disable 0 puts the bus clock on pin 4, free running unless stretched.
// - Bus clock can appear on pin 4 in every mode.
// - Low strobe enable is bit 3; set puts the low-byte strobe on pin 3.
// - Tag-low sampled on bus clock rise; strobe driven on bus clock fall while tagging is enabled, every clock otherwise.
// - Low strobe enable ignored in single-chip, peripheral and normal narrow modes.
// - Read/write enable is bit 2; set makes pin 2 the read/write signal.
// - Mode register: code 7:5, visibility 3, emulate K 1, emulate E 0.
// - Mode code reset from strap; visibility and emulate bits reset per mode.
// - Peripheral mode hides the mode register but keeps its reset values.
// - Mode register writes take effect one cycle after the write.
// - Expanded and peripheral modes pass mode register accesses to the external bus.
// - Mode register readable while mapped; the code field and each flag bit have their own permission.
// - Code never writable with low bit 1; never to or from peripheral.
// - Selected alternate functions override the pin direction bit.
// - Special test and emulation reset with pipe, clock, low strobe and read/write pins assigned.
// - Emulate E in expanded or peripheral removes port E data and direction.
//
// Design decision made here: the plain strobed port.
`include "bus_ctrl_params.svh"
module bus_ctrl_pin_assign_mode_reg
  import bus_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Strapped mode and security.
  input  wire logic [2:0]        mode_strap,
  input  wire logic              secure,
  // Register port.
  input  wire logic [`ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic [7:0]             rdata,
  output logic                   ext_access,
  // Bus control sources from the bus engine.
  input  wire logic              free_cycle,
  input  wire logic [1:0]        pipe_status,
  input  wire logic              bus_clock_stretch_sel,
  input  wire logic              rw_level,
  input  wire logic              low_byte_strobe,
  input  wire logic              tag_enable,
  input  wire logic              tag_low_pin,
  // General I/O values and directions for port E pins 7 to 2.
  input  wire logic [7:2]        gpio_out,
  input  wire logic [7:2]        gpio_dir,
  // Pin outputs and enables.
  output logic [7:2]             pe_out,
  output logic [7:2]             pe_oe,
  // Configuration state for the rest of the device.
  output logic [2:0]             mode_code,
  output logic                   internal_visibility,
  output logic                   emulate_port_k,
  output logic                   emulate_port_e,
  output logic                   port_e_regs_mapped,
  output logic                   tag_low_input,
  output logic                   bus_clock_out
);

  // Reset values load only once the strap has passed both synchroniser stages.
  // A write that lands before the load edge is overwritten by the reset values.
  logic [2:0] strap_s1_q;
  logic [2:0] strap_s2_q;
  logic       load_q;
  logic       started_q;
  logic       armed_q;

  // The strap is a static level, so two plain stages are enough to settle it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
      started_q  <= 1'b0;
      armed_q    <= 1'b0;
      load_q     <= 1'b0;
    end else begin
      strap_s1_q <= mode_strap;
      strap_s2_q <= strap_s1_q;
      started_q  <= 1'b1;
      armed_q    <= started_q;
      load_q     <= started_q && !armed_q;
    end
  end

  // Mode state held in the mode register.
  // Only the code lives here; visibility and emulate bits sit in permission cells.
  logic [2:0] code_q;
  logic       vis_q;
  logic       emk_q;
  logic       eme_q;
  logic       code_lock_q;
  logic [2:0] rst_code;

  // The second stage holds the strap by the third edge after release, when load fires.
  assign rst_code = strap_s2_q;

  // Special test counts as neither single chip nor expanded, so its registers stay mapped.
  // Mode classification.
  mode_class_type cls;
  logic is_emu;
  logic is_single;
  logic is_periph;
  logic is_expanded;
  logic is_norm_narrow;
  logic rst_emu;
  logic rst_test;

  assign is_emu         = (code_q == `MODE_EMU_NARROW) || (code_q == `MODE_EMU_WIDE);
  assign is_single      = (code_q == `MODE_SPEC_SC) || (code_q == `MODE_NORM_SC);
  assign is_periph      = (code_q == `MODE_SPEC_PERIPH);
  assign is_expanded    = !is_single && !is_periph && (code_q != `MODE_SPEC_TEST);
  assign is_norm_narrow = (code_q == `MODE_NORM_NARROW);
  assign cls            = is_emu ? CLASS_EMULATION :
                          (code_q[2] && !is_periph) ? CLASS_NORMAL : CLASS_SPECIAL;
  assign rst_emu        = (rst_code == `MODE_EMU_NARROW) || (rst_code == `MODE_EMU_WIDE);
  assign rst_test       = (rst_code == `MODE_SPEC_TEST);

  // Address decoding and map presence.
  // Hidden registers still raise ext_access so the bus engine can echo the cycle outside.
  // The flag is combinational and stands only while the strobe stands.
  logic fa_hit;
  logic mc_hit;
  logic regs_mapped;

  assign regs_mapped = !is_expanded && !is_periph;
  assign fa_hit      = regs_mapped && (addr == `OFF_FUNC_ASSIGN);
  assign mc_hit      = regs_mapped && (addr == `OFF_MODE_CONTROL);
  assign ext_access  = (rd_en || wr_en) &&
                       ((addr == `OFF_FUNC_ASSIGN) || (addr == `OFF_MODE_CONTROL)) &&
                       !regs_mapped;

  // Function assignment bits, each through the permission cell.
  // Every cell sees every write to its register, so a write-once bit locks even when its
  // value does not change; software should set all such bits in one write.
  logic fa_wr;
  logic mc_wr;
  logic free_en_q;
  logic pipe_en_q;
  logic clk_dis_q;
  logic lstr_en_q;
  logic rw_en_q;
  logic bus_ctl_rst;

  // Secure state blocks only the mode register; the function assignment stays writable.
  assign fa_wr       = wr_en && fa_hit;
  assign mc_wr       = wr_en && mc_hit && !secure;
  assign bus_ctl_rst = rst_emu || rst_test;

  wr_once_bit u_free (
    .clk(clk), .rst_n(rst_n), .load(load_q), .load_val(rst_emu),
    .wr(fa_wr), .wr_val(wdata[`FA_FREE_CYCLE]), .cls(cls),
    .once_in_normal(1'b1), .never_in_normal(1'b0), .val_q(free_en_q)
  );
  wr_once_bit u_pipe (
    .clk(clk), .rst_n(rst_n), .load(load_q), .load_val(bus_ctl_rst),
    .wr(fa_wr), .wr_val(wdata[`FA_PIPE_STATUS]), .cls(cls),
    .once_in_normal(1'b1), .never_in_normal(1'b0), .val_q(pipe_en_q)
  );
  wr_once_bit u_clkdis (
    .clk(clk), .rst_n(rst_n), .load(load_q), .load_val(rst_code == `MODE_NORM_SC),
    .wr(fa_wr), .wr_val(wdata[`FA_CLK_DISABLE]), .cls(cls),
    .once_in_normal(1'b0), .never_in_normal(1'b0), .val_q(clk_dis_q)
  );
  wr_once_bit u_lstr (
    .clk(clk), .rst_n(rst_n), .load(load_q), .load_val(bus_ctl_rst),
    .wr(fa_wr), .wr_val(wdata[`FA_LOW_STROBE]), .cls(cls),
    .once_in_normal(1'b1), .never_in_normal(1'b0), .val_q(lstr_en_q)
  );
  wr_once_bit u_rw (
    .clk(clk), .rst_n(rst_n), .load(load_q), .load_val(bus_ctl_rst),
    .wr(fa_wr), .wr_val(wdata[`FA_RW_PIN]), .cls(cls),
    .once_in_normal(1'b1), .never_in_normal(1'b0), .val_q(rw_en_q)
  );

  // Visibility and emulate K share the write-once pattern; emulate E is special only.
  // A write in secure state reaches none of these cells, as mc_wr is already gated.
  wr_once_bit u_vis (
    .clk(clk), .rst_n(rst_n), .load(load_q), .load_val(bus_ctl_rst),
    .wr(mc_wr), .wr_val(wdata[`MC_VIS]), .cls(cls),
    .once_in_normal(1'b1), .never_in_normal(1'b0), .val_q(vis_q)
  );
  wr_once_bit u_emk (
    .clk(clk), .rst_n(rst_n), .load(load_q), .load_val(rst_emu),
    .wr(mc_wr), .wr_val(wdata[`MC_EMU_K]), .cls(cls),
    .once_in_normal(1'b1), .never_in_normal(1'b0), .val_q(emk_q)
  );
  wr_once_bit u_eme (
    .clk(clk), .rst_n(rst_n), .load(load_q), .load_val(rst_emu),
    .wr(mc_wr), .wr_val(wdata[`MC_EMU_E]), .cls(cls),
    .once_in_normal(1'b0), .never_in_normal(1'b1), .val_q(eme_q)
  );

  // Mode code write permission.
  // Codes with the low bit set are final; special modes may move anywhere but peripheral.
  // From normal single chip only the two normal expanded codes can be reached.
  logic [2:0] new_code;
  logic       code_ok;

  assign new_code = wdata[`MC_CODE_HI:`MC_CODE_LO];
  assign code_ok  = mc_wr && !code_q[0] && (new_code != `MODE_SPEC_PERIPH) &&
                    ((!code_q[2]) ||
                     (!code_lock_q && new_code[2] == 1'b1 && new_code[0] == 1'b1));

  // Writing normal single chip from a special mode leaves one write; codes with the low bit set leave none.
  // The lock only matters in normal single chip, where one more code write may remain.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q      <= 3'h0;
      code_lock_q <= 1'b0;
    end else if (load_q) begin
      code_q      <= rst_code;
      code_lock_q <= 1'b0;
    end else if (code_ok) begin
      code_q      <= new_code;
      code_lock_q <= code_q[2];
    end
  end

  // Outputs use the stored values, so a write shows one cycle after its strobe.
  assign mode_code           = code_q;
  assign internal_visibility = vis_q;
  assign emulate_port_k      = emk_q;
  assign emulate_port_e      = eme_q;
  // Peripheral mode never maps the port E data and direction registers.
  // Emulate E removes them in the expanded modes; single-chip modes always keep them.
  assign port_e_regs_mapped  = !is_periph && (is_single || !(eme_q && is_expanded));

  // Read data, registered one cycle after the strobe.
  // Bits without storage read as zero, and idle or unmapped cycles return zero as well.
  logic [7:0] fa_rd;
  logic [7:0] mc_rd;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  assign fa_rd   = {free_en_q, 1'b0, pipe_en_q, clk_dis_q, lstr_en_q, rw_en_q, 2'b00};
  assign mc_rd   = {code_q, 1'b0, vis_q, 1'b0, emk_q, eme_q} & `MC_IMPL_MASK;
  assign rdata_d = !rd_en ? 8'h00 : fa_hit ? fa_rd : mc_hit ? mc_rd : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Read data follow the read strobe one cycle later and fall back to zero once it drops.
  assign rdata = rdata_q;

  // Bus clock generation from the system clock.
  // The divider stops while stretch is set, so the pin holds its level instead of glitching.
  logic bclk_lvl;
  logic bclk_rise;
  logic bclk_fall;

  bus_clk_div #(
    .HALF_CYC(`BUS_CLK_HALF_CYC)
  ) u_div (
    .clk(clk), .rst_n(rst_n), .stretch(bus_clock_stretch_sel),
    .clk_lvl_q(bclk_lvl), .rise(bclk_rise), .fall(bclk_fall)
  );

  // Tag-low pin synchroniser; only the second stage is read.
  // With tagging off the strobe is registered from the engine on every system clock, trading phase for latency.
  logic tag_s1_q;
  logic tag_s2_q;
  logic tag_q;
  logic low_byte_strobe_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tag_s1_q <= 1'b0;
      tag_s2_q <= 1'b0;
      tag_q    <= 1'b0;
      low_byte_strobe_q  <= 1'b1;
    end else begin
      tag_s1_q <= tag_low_pin;
      tag_s2_q <= tag_s1_q;
      if (tag_enable && bclk_rise) begin
        tag_q <= tag_s2_q;
      end
      if (!tag_enable || bclk_fall) begin
        low_byte_strobe_q <= low_byte_strobe;
      end
    end
  end

  // The captured tag holds its last value while tagging is off.
  assign tag_low_input = tag_q;
  assign bus_clock_out = bclk_lvl;

  // Effective pin functions after the mode masks.
  // Enables keep their stored value in masked modes; only the selection ignores them,
  // so leaving a single-chip mode restores what software wrote.
  logic free_sel;
  logic pipe_sel;
  logic clk_sel;
  logic lstr_sel;
  logic rw_sel;
  logic bus_ctl_ok;

  assign bus_ctl_ok = !is_single && !is_periph;
  assign free_sel   = bus_ctl_ok && !free_en_q;
  assign pipe_sel   = bus_ctl_ok && pipe_en_q;
  assign clk_sel    = !clk_dis_q;
  assign lstr_sel   = bus_ctl_ok && !is_norm_narrow && lstr_en_q;
  assign rw_sel     = bus_ctl_ok && rw_en_q;

  // Alternate functions override the direction register.
  // The override is combinational, so a mode write moves pe_oe together with the state.
  logic [7:2] alt_sel;
  logic [7:2] alt_val;
  logic [7:2] pe_out_d;
  logic [7:2] pe_out_q;

  assign alt_sel  = {free_sel, pipe_sel, pipe_sel, clk_sel, lstr_sel, rw_sel};
  assign alt_val  = {free_cycle, pipe_status, bclk_lvl, low_byte_strobe_q, rw_level};
  assign pe_out_d = (alt_sel & alt_val) | (~alt_sel & gpio_out);
  assign pe_oe    = alt_sel | gpio_dir;

  // Pin values are registered to keep selection glitches off the pads.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pe_out_q <= 6'h00;
    end else begin
      pe_out_q <= pe_out_d;
    end
  end

  assign pe_out = pe_out_q;

endmodule

// file: design/bus_ctrl_params.svh
// Offsets, field positions, mode codes and timing counts of the bus control configuration.
`ifndef BUS_CTRL_PARAMS_SVH
`define BUS_CTRL_PARAMS_SVH

// Register offsets.
`define ADDR_W             8
`define OFF_FUNC_ASSIGN    8'h0a
`define OFF_MODE_CONTROL   8'h0b

// Function assignment register fields.
`define FA_FREE_CYCLE      7
`define FA_PIPE_STATUS     5
`define FA_CLK_DISABLE     4
`define FA_LOW_STROBE      3
`define FA_RW_PIN          2
`define FA_IMPL_MASK       8'hbc

// Mode register fields.
`define MC_CODE_HI         7
`define MC_CODE_LO         5
`define MC_VIS             3
`define MC_EMU_K           1
`define MC_EMU_E           0
`define MC_IMPL_MASK       8'heb

// Mode codes.
`define MODE_SPEC_SC       3'h0
`define MODE_EMU_NARROW    3'h1
`define MODE_SPEC_TEST     3'h2
`define MODE_EMU_WIDE      3'h3
`define MODE_NORM_SC       3'h4
`define MODE_NORM_NARROW   3'h5
`define MODE_SPEC_PERIPH   3'h6
`define MODE_NORM_WIDE     3'h7

// Bus clock divider: one bus clock half period in system clocks.
`define BUS_CLK_HALF_NS    10
`define CLK_PERIOD_NS      10
`define BUS_CLK_HALF_CYC   ((`BUS_CLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: design/bus_ctrl_pkg.sv
// Types shared by the bus control configuration logic.
package bus_ctrl_pkg;

  // Mode classes derived from the three-bit mode code.
  typedef enum logic [2:0] {
    CLASS_NORMAL    = 3'b001,
    CLASS_EMULATION = 3'b010,
    CLASS_SPECIAL   = 3'b100
  } mode_class_type;

  typedef logic [7:0] reg_byte_type;

endpackage

// file: design/wr_once_bit.sv
// One configuration bit with mode-dependent write permission and a write-once lock.
module wr_once_bit
  import bus_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Reset load, taken at the third clock edge after release.
  input  wire logic           load,
  input  wire logic           load_val,
  // Write request.
  input  wire logic           wr,
  input  wire logic           wr_val,
  input  wire mode_class_type cls,
  input  wire logic           once_in_normal,
  input  wire logic           never_in_normal,
  // Stored value.
  output logic                val_q
);

  logic lock_q;
  logic allow;

  // Normal mode allows one write unless the bit is anytime or never there.
  assign allow = (cls == CLASS_SPECIAL) ||
                 ((cls == CLASS_NORMAL) && !never_in_normal && (!once_in_normal || !lock_q));

  // The lock closes on the first accepted write, so later normal-mode writes to a write-once bit are dropped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_q  <= 1'b0;
      lock_q <= 1'b0;
    end else if (load) begin
      val_q  <= load_val;
      lock_q <= 1'b0;
    end else if (wr && allow) begin
      val_q  <= wr_val;
      lock_q <= 1'b1;
    end
  end

endmodule

// file: design/bus_clk_div.sv
// Bus clock divider producing the clock level and rising and falling edge pulses.
module bus_clk_div #(
  parameter int HALF_CYC = 1
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Stretch select holds the clock when set.
  input  wire logic stretch,
  // Outputs.
  output logic      clk_lvl_q,
  output logic      rise,
  output logic      fall
);

  logic [7:0] cnt_q;
  logic       wrap;

  assign wrap = (cnt_q == 8'(HALF_CYC - 1));
  assign rise = wrap && !stretch && !clk_lvl_q;
  assign fall = wrap && !stretch && clk_lvl_q;

  // Free running while the stretch select is clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= 8'h00;
      clk_lvl_q <= 1'b0;
    end else if (!stretch) begin
      cnt_q     <= wrap ? 8'h00 : cnt_q + 8'h01;
      clk_lvl_q <= wrap ? !clk_lvl_q : clk_lvl_q;
    end
  end

endmodule

// file: bench/bus_ctrl_monitor.sv
// Concurrent checks on the ports of the bus control configuration block.
`include "bus_ctrl_params.svh"
module bus_ctrl_monitor (
  // Clock and reset.
  input wire logic               clk,
  input wire logic               rst_n,
  // Register port.
  input wire logic               secure,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [7:0]         wdata,
  input wire logic               wr_en,
  input wire logic               rd_en,
  input wire logic [7:0]         rdata,
  input wire logic               ext_access,
  // Pins and state.
  input wire logic [1:0]         pipe_status,
  input wire logic               bus_clock_stretch_sel,
  input wire logic [7:2]         gpio_dir,
  input wire logic [7:2]         pe_out,
  input wire logic [7:2]         pe_oe,
  input wire logic [2:0]         mode_code,
  input wire logic               bus_clock_out,
  // Tag capture.
  input wire logic               tag_enable,
  input wire logic               tag_low_pin,
  input wire logic               tag_low_input
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Address decode shared by the checks.
  wire mode_hit = addr == `OFF_MODE_CONTROL;
  wire reg_hit  = mode_hit || addr == `OFF_FUNC_ASSIGN;

  rdata_idle_a: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_rd_a: assert property (rd_en && !reg_hit |=> rdata == 8'h00)
    else $error("unmapped read returned data");
  mode_layout_a: assert property (rd_en && mode_hit && !ext_access |=>
    rdata[4] == 1'b0 && rdata[2] == 1'b0 && rdata[7:5] == $past(mode_code))
    else $error("mode register read layout wrong");
  ext_route_a: assert property ((rd_en || wr_en) && reg_hit &&
    !(mode_code inside {3'h0, 3'h2, 3'h4}) |-> ext_access)
    else $error("hidden register access not routed out");
  secure_hold_a: assert property (wr_en && secure && mode_hit |=> $stable(mode_code))
    else $error("mode changed in secure state");
  never_write_a: assert property (mode_code[0] |=> $stable(mode_code))
    else $error("mode code changed with low bit set");
  no_periph_a: assert property (wr_en && mode_hit && wdata[7:5] == 3'h6 &&
    mode_code != 3'h6 |=> mode_code != 3'h6)
    else $error("mode entered peripheral by write");
  single_pins_a: assert property (mode_code inside {3'h0, 3'h4, 3'h6} |->
    {pe_oe[7:5], pe_oe[3:2]} == {gpio_dir[7:5], gpio_dir[3:2]})
    else $error("bus control pin active in single chip mode");
  narrow_strobe_a: assert property (mode_code == 3'h5 |-> pe_oe[3] == gpio_dir[3])
    else $error("low strobe active in narrow mode");
  clk_toggle_a: assert property ((!bus_clock_stretch_sel) [*3] |->
    bus_clock_out != $past(bus_clock_out))
    else $error("bus clock not free running");
  pipe_drive_a: assert property ((pe_oe[6] && !gpio_dir[6]) [*2] |->
    pe_out[6:5] == $past(pipe_status))
    else $error("pipe status pins wrong");
  tag_capture_a: assert property (tag_enable && !bus_clock_stretch_sel && !bus_clock_out |=>
    tag_low_input == $past(tag_low_pin, 3))
    else $error("tag low not captured at bus clock rise");

  // Main scenarios reached.
  cover property (wr_en && mode_hit && secure);
  cover property (ext_access);
  cover property (pe_oe[6] && mode_code == 3'h7);
endmodule

bind bus_ctrl_pin_assign_mode_reg bus_ctrl_monitor i_monitor (.clk, .rst_n, .secure, .addr,
  .wdata, .wr_en, .rd_en, .rdata, .ext_access, .pipe_status, .bus_clock_stretch_sel,
  .gpio_dir, .pe_out, .pe_oe, .mode_code, .bus_clock_out, .tag_enable, .tag_low_pin,
  .tag_low_input);

// file: bench/bus_engine_model.sv
// Behavioural bus engine that feeds the bus control sources of port E.
module bus_engine_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Bus control sources.
  output logic       free_cycle,
  output logic [1:0] pipe_status,
  output logic       bus_clock_stretch_sel,
  output logic       rw_level,
  output logic       low_byte_strobe,
  output logic       tag_enable,
  output logic       tag_low_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] step_q;

  // A pattern that changes every cycle, so a stuck pin selection cannot hide.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) step_q <= 4'h0;
    else step_q <= step_q + 4'h1;
  end

  // Sources follow the step counter; stretching stays off so the bus clock free-runs.
  assign pipe_status           = step_q[1:0];
  assign free_cycle            = step_q[2];
  assign rw_level              = step_q[3];
  assign low_byte_strobe       = ~step_q[0];
  assign bus_clock_stretch_sel = 1'b0;
  assign tag_enable            = step_q[3];
  assign tag_low_pin           = step_q[2];
endmodule

// file: bench/bus_ctrl_pin_assign_mode_reg_tb.sv
// Self-checking bench for the port E function assignment and mode register.
`include "bus_ctrl_params.svh"
module bus_ctrl_pin_assign_mode_reg_tb
  import bus_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_n = 1'b0, secure = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [2:0] mode_strap = 3'h0, mode_code, pre_mode;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got;
  logic [7:2] gpio_out = 6'h00, gpio_dir = 6'h00, pe_out, pe_oe;
  logic [1:0] pipe_status;
  logic       ext_access, ext_seen, free_cycle, rw_level, low_byte_strobe, tag_enable;
  logic       tag_low_pin, bus_clock_stretch_sel, tag_low_input, bus_clock_out;
  logic       internal_visibility, emulate_port_k, emulate_port_e, port_e_regs_mapped;
  int         fail_count = 0, compares = 0;
  logic [7:0] mode_rst [8] = '{8'h00, 8'h2b, 8'h48, 8'h6b, 8'h80, 8'ha0, 8'hc0, 8'he0};
  logic [7:0] fa_rst [8]   = '{8'h00, 8'hac, 8'h2c, 8'hac, 8'h10, 8'h00, 8'h00, 8'h00};

  always #5 clk = ~clk;

  bus_ctrl_pin_assign_mode_reg i_dut (.clk, .rst_n, .mode_strap, .secure, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .ext_access, .free_cycle, .pipe_status, .bus_clock_stretch_sel,
    .rw_level, .low_byte_strobe, .tag_enable, .tag_low_pin, .gpio_out, .gpio_dir, .pe_out,
    .pe_oe, .mode_code, .internal_visibility, .emulate_port_k, .emulate_port_e,
    .port_e_regs_mapped, .tag_low_input, .bus_clock_out);
  bus_engine_model i_model (.clk, .rst_n, .free_cycle, .pipe_status, .bus_clock_stretch_sel,
    .rw_level, .low_byte_strobe, .tag_enable, .tag_low_pin);

  // Comparison and verdict.
  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Strap must stay steady through the synchroniser, so it is set with reset.
  task automatic do_reset(input logic [2:0] strap);
    @(posedge clk);
    rst_n <= 1'b0;
    mode_strap <= strap;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Bus cycles end at a falling edge so the new state is settled for checks.
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(negedge clk);
    pre_mode = mode_code;
    @(posedge clk);
    wr_en <= 1'b0;
    @(negedge clk);
  endtask
  task automatic read_expect(input string what, input logic [7:0] a, input logic [7:0] exp,
                             input logic ext);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(negedge clk);
    ext_seen = ext_access;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check_val(what, exp, rdata);
    check_val({what, " route"}, {7'h00, ext}, {7'h00, ext_seen});
  endtask
  // Pin enables with every direction bit clear: only a selected alternate output drives the pin.
  function automatic logic [7:2] exp_oe(input logic [7:0] fa, input logic [2:0] code);
    logic sc;
    sc = code inside {3'h0, 3'h4, 3'h6};
    return {~fa[7] & ~sc, {2{fa[5] & ~sc}}, ~fa[4], fa[3] & ~sc & (code != 3'h5), fa[2] & ~sc};
  endfunction

  task automatic reset_values_test();
    logic mapped;
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s));
      mapped = s == 0 || s == 4;
      @(negedge clk);
      check_val("mode code", {5'h00, 3'(s)}, {5'h00, mode_code});
      check_val("mode flags", {5'h00, mode_rst[s][3], mode_rst[s][1:0]},
        {5'h00, internal_visibility, emulate_port_k, emulate_port_e});
      check_val("regs mapped", {7'h00, mapped || (s != 6 && !mode_rst[s][0])},
        {7'h00, port_e_regs_mapped});
      check_val("pin enables", {2'h0, exp_oe(fa_rst[s], 3'(s))}, {2'h0, pe_oe});
      if (s != 2) begin
        read_expect("mode reg", `OFF_MODE_CONTROL, mapped ? mode_rst[s] : 8'h00, !mapped);
        read_expect("assign reg", `OFF_FUNC_ASSIGN, mapped ? fa_rst[s] : 8'h00, !mapped);
      end
    end
  endtask

  task automatic special_write_test();
    do_reset(3'h0);
    bus_wr(`OFF_FUNC_ASSIGN, 8'hff);
    read_expect("assign all", `OFF_FUNC_ASSIGN, 8'hbc, 1'b0);
    bus_wr(`OFF_FUNC_ASSIGN, 8'h00);
    read_expect("assign clear", `OFF_FUNC_ASSIGN, 8'h00, 1'b0);
    bus_wr(`OFF_MODE_CONTROL, 8'h1e);
    read_expect("mode bits", `OFF_MODE_CONTROL, 8'h0a, 1'b0);
    @(posedge clk);
    secure <= 1'b1;
    bus_wr(`OFF_MODE_CONTROL, 8'h00);
    read_expect("secure mode", `OFF_MODE_CONTROL, 8'h0a, 1'b0);
    @(posedge clk);
    secure <= 1'b0;
    bus_wr(`OFF_MODE_CONTROL, 8'hca);
    read_expect("no peripheral", `OFF_MODE_CONTROL, 8'h0a, 1'b0);
    bus_wr(`OFF_MODE_CONTROL, 8'h8a);
    check_val("mode delay", 8'h00, {5'h00, pre_mode});
    check_val("mode applied", 8'h04, {5'h00, mode_code});
  endtask

  task automatic normal_once_test();
    do_reset(3'h4);
    bus_wr(`OFF_FUNC_ASSIGN, 8'hac);
    read_expect("assign first", `OFF_FUNC_ASSIGN, 8'hac, 1'b0);
    @(posedge clk);
    gpio_dir <= 6'h2a;
    @(negedge clk);
    check_val("single chip pins", 8'h2e, {2'h0, pe_oe});
    @(posedge clk);
    gpio_dir <= 6'h00;
    bus_wr(`OFF_FUNC_ASSIGN, 8'h14);
    read_expect("assign locked", `OFF_FUNC_ASSIGN, 8'hbc, 1'b0);
    bus_wr(`OFF_FUNC_ASSIGN, 8'h00);
    read_expect("clock pin anytime", `OFF_FUNC_ASSIGN, 8'hac, 1'b0);
    bus_wr(`OFF_MODE_CONTROL, 8'he0);
    check_val("expanded wide", 8'h07, {5'h00, mode_code});
    check_val("wide pins", 8'h1f, {2'h0, pe_oe});
    read_expect("assign hidden", `OFF_FUNC_ASSIGN, 8'h00, 1'b1);
    bus_wr(`OFF_MODE_CONTROL, 8'h80);
    check_val("code frozen", 8'h07, {5'h00, mode_code});
  endtask

  // Main sequence.
  initial begin
    reset_values_test();
    special_write_test();
    normal_once_test();
    tally_and_finish();
  end
  // Hang guard.
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
